// file: hw/aud_out_pkg.sv
/*
 * Constants, field layout and ratio helpers of the audio output port.
 * Assumes a single system clock; pin clocks are sampled, not used as clocks.
 */
package aud_out_pkg;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MAP    = 8'h08;
    localparam logic [7:0] REG_CSTAT  = 8'h0c;
    localparam logic [7:0] REG_CH0    = 8'h10;
    localparam logic [7:0] REG_CH5    = 8'h24;

    // Control field positions
    localparam int CTRL_MCLK_OUT = 0;
    localparam int CTRL_MASTER   = 1;
    localparam int CTRL_MRAT_LSB = 2;
    localparam int CTRL_SRAT_LSB = 4;
    localparam int CTRL_FMT_LSB  = 7;
    localparam int CTRL_DELAY    = 9;
    localparam int CTRL_WORD_LSB = 10;
    localparam int CTRL_L0CH_LSB = 15;
    localparam int CTRL_FALL     = 17;
    localparam int CTRL_DEN_LSB  = 18;
    localparam int CTRL_TX_EN    = 21;
    localparam int CTRL_TX_MCLK  = 22;
    localparam int CTRL_TX_CMP   = 23;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Serialiser and transmitter constants
    localparam logic [4:0] SAMPLE_W     = 5'h14;
    localparam logic [5:0] HC_LAST      = 6'h3f;
    localparam logic [7:0] BLOCK_LAST   = 8'hbf;
    localparam logic [7:0] CSTAT_BITS   = 8'h20;
    localparam logic [7:0] PRE_BLOCK    = 8'he8;
    localparam logic [7:0] PRE_SUB_A    = 8'he2;
    localparam logic [7:0] PRE_SUB_B    = 8'he4;
    localparam logic [7:0] TX_EDGES_256 = 8'h04;
    localparam logic [7:0] TX_EDGES_512 = 8'h08;

    typedef enum logic [1:0] {
        M128 = 2'h0, M256 = 2'h1, M384 = 2'h2, M512 = 2'h3
    } mrat_type;

    typedef enum logic [2:0] {
        S32 = 3'h0, S48 = 3'h1, S64 = 3'h2, S128 = 3'h3, S256 = 3'h4, S512 = 3'h5
    } srat_type;

    typedef enum logic [1:0] {
        FMT_LJ = 2'h0, FMT_I2S = 2'h1, FMT_RJ = 2'h2, FMT_MC = 2'h3
    } fmt_type;

    // Master clock multiple of Fs
    function automatic logic [9:0] mclk_mult(input mrat_type m);
        case (m)
            M128:    return 10'h080;
            M256:    return 10'h100;
            M384:    return 10'h180;
            default: return 10'h200;
        endcase
    endfunction

    // Bit clock multiple of Fs
    function automatic logic [9:0] sclk_mult(input srat_type s);
        case (s)
            S32:     return 10'h020;
            S48:     return 10'h030;
            S64:     return 10'h040;
            S128:    return 10'h080;
            S256:    return 10'h100;
            default: return 10'h200;
        endcase
    endfunction

    // Allowed master and bit clock pairs
    function automatic logic ratio_legal(input mrat_type m, input srat_type s, input logic drive);
        case (m)
            M128:    return s == S32 || s == S64;
            M256:    return s == S32 || s == S64 || s == S128 || s == S256;
            M384:    return !drive && (s == S32 || s == S48 || s == S64);
            default: return s == S32 || s == S64 || s == S128 || s == S256 || s == S512;
        endcase
    endfunction

endpackage

// file: hw/aud_out_port.sv
/*
 * Audio output port: three serial data lines, master/slave bit and frame
 * clocks, master clock pin, and a biphase transmitter output.
 * Assumes I_CLOCK is at least four times faster than any pin clock.
 */
// Our own choices: the address map and the address-and-strobe port.
module aud_out_port #(
    parameter int MCLK_HALF_CYC = 4,
    parameter int TX_HALF_CYC   = 16
) (
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST_B,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_mclk,
    output logic             o_mclk,
    output logic             o_mclk_oe_n,
    input  wire logic        i_sclk,
    output logic             o_sclk,
    output logic             o_sclk_oe_n,
    input  wire logic        i_lrclk,
    output logic             o_lrclk,
    output logic             o_lrclk_oe_n,
    output logic             o_audio_data_line_0,
    output logic             o_audio_data_line_1,
    output logic             o_audio_data_line_2,
    output logic             o_biphase_tx_out
);

    typedef struct packed {
        logic [31:0]      ctrl;
        logic [17:0]      map;
        logic [31:0]      cstat;
        logic [5:0][19:0] ch;
        logic [31:0]      rdata;
        logic [7:0]       mdiv;
        logic             mclk_int;
        logic [2:0]       mclk_s;
        logic [2:0]       sclk_s;
        logic [2:0]       lr_s;
        logic [9:0]       ecnt;
        logic             sclk;
        logic             lr;
        logic [9:0]       mbit;
        logic             mclk_oe_n;
        logic             sclk_oe_n;
        logic             lr_oe_n;
        logic [9:0]       bitcnt;
        logic [9:0]       half_len;
        logic             lr_prev;
        logic [1:0]       settle;
        logic [2:0][19:0] sh;
        logic [2:0][1:0]  slot;
        logic [2:0][4:0]  sbit;
        logic [2:0]       act;
        logic [2:0]       dout;
        logic [7:0]       tdiv;
        logic [5:0]       hc;
        logic             sub;
        logic [7:0]       frame;
        logic [31:0]      tword;
        logic [7:0]       tpre;
        logic             tpol;
        logic             tline;
    } state_type;

    state_type                q;
    state_type                n;
    logic                     master;
    logic                     pol;
    aud_out_pkg::fmt_type     fmt;
    aud_out_pkg::mrat_type    msel;
    aud_out_pkg::srat_type    ssel;
    logic                     clk_ok;
    logic                     mtog;
    logic                     mclk_edge;
    logic [9:0]               ediv;
    logic [9:0]               half_bits;
    logic [4:0]               word;
    logic [1:0]               slots0;
    logic [2:0]               den;
    logic                     shift_ev;
    logic                     lr_now;
    logic                     lr_chg;
    logic                     left;
    logic [9:0]               nc;
    logic [2:0]               load;
    logic                     tx_ok;
    logic                     tx_tick;
    logic [7:0]               tterm;
    logic                     tinc;
    logic [5:0]               nh;

    // Channel register address check
    function automatic logic ch_hit(input logic [7:0] a);
        return a >= aud_out_pkg::REG_CH0 && a <= aud_out_pkg::REG_CH5 && a[1:0] == 2'h0;
    endfunction

    // Channel register index from address
    function automatic logic [2:0] ch_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - aud_out_pkg::REG_CH0;
        return off[4:2];
    endfunction

    // Sample moved to the top of the shifter
    function automatic logic [19:0] align(input logic [19:0] s, input logic [4:0] w);
        return s << (aud_out_pkg::SAMPLE_W - w);
    endfunction

    // Configuration decode
    assign master    = q.ctrl[aud_out_pkg::CTRL_MASTER];
    assign pol       = q.ctrl[aud_out_pkg::CTRL_FALL];
    assign fmt       = aud_out_pkg::fmt_type'(q.ctrl[aud_out_pkg::CTRL_FMT_LSB +: 2]);
    assign msel      = aud_out_pkg::mrat_type'(q.ctrl[aud_out_pkg::CTRL_MRAT_LSB +: 2]);
    assign ssel      = aud_out_pkg::srat_type'(q.ctrl[aud_out_pkg::CTRL_SRAT_LSB +: 3]);
    assign den       = q.ctrl[aud_out_pkg::CTRL_DEN_LSB +: 3];
    assign clk_ok    = aud_out_pkg::ratio_legal(msel, ssel,
                                                q.ctrl[aud_out_pkg::CTRL_MCLK_OUT]);
    assign ediv      = aud_out_pkg::mclk_mult(msel) / aud_out_pkg::sclk_mult(ssel);
    assign half_bits = aud_out_pkg::sclk_mult(ssel) >> 1;
    assign mtog      = q.mdiv >= 8'(MCLK_HALF_CYC - 1);
    assign mclk_edge = q.ctrl[aud_out_pkg::CTRL_MCLK_OUT] ? mtog
                                                          : (q.mclk_s[1] ^ q.mclk_s[2]);
    // Word size, capped to the sample width
    assign word   = (fmt == aud_out_pkg::FMT_MC || q.ctrl[aud_out_pkg::CTRL_WORD_LSB +: 5] == 5'h0
                    || q.ctrl[aud_out_pkg::CTRL_WORD_LSB +: 5] > aud_out_pkg::SAMPLE_W)
                    ? aud_out_pkg::SAMPLE_W : q.ctrl[aud_out_pkg::CTRL_WORD_LSB +: 5];
    assign slots0 = (fmt == aud_out_pkg::FMT_MC) ? 2'h3
                  : 2'(q.ctrl[aud_out_pkg::CTRL_L0CH_LSB +: 2] + 2'h1);

    // Next state
    always_comb begin
        logic [9:0]  st;
        logic [1:0]  slots;
        logic [2:0]  lch;
        logic [2:0]  src;
        logic [1:0]  sl;
        logic [19:0] smp;
        logic        nsub;
        logic [7:0]  nfr;
        logic [31:0] w;
        st     = '0;
        slots  = '0;
        lch    = '0;
        src    = '0;
        sl     = '0;
        smp    = '0;
        nsub   = 1'b0;
        nfr    = '0;
        w      = '0;
        n      = q;
        n.rdata = '0;
        // Register writes
        if (i_wr) begin
            case (i_addr)
                aud_out_pkg::REG_CTRL: begin
                    n.ctrl   = i_wdata;
                    n.settle = '0;
                end
                aud_out_pkg::REG_MAP:   n.map   = i_wdata[17:0];
                aud_out_pkg::REG_CSTAT: n.cstat = i_wdata;
                default: begin
                    if (ch_hit(i_addr)) begin
                        n.ch[ch_idx(i_addr)] = i_wdata[19:0];
                    end
                end
            endcase
        end
        // Pin synchronisers
        n.mclk_s = {q.mclk_s[1:0], i_mclk};
        n.sclk_s = {q.sclk_s[1:0], i_sclk};
        n.lr_s   = {q.lr_s[1:0], i_lrclk};
        // Internal PLL stand-in and pin directions
        n.mdiv = mtog ? 8'h0 : 8'(q.mdiv + 8'h1);
        if (mtog) begin
            n.mclk_int = ~q.mclk_int;
        end
        n.mclk_oe_n = ~q.ctrl[aud_out_pkg::CTRL_MCLK_OUT];
        n.sclk_oe_n = ~master;
        n.lr_oe_n   = ~master;
        // Bit and frame clock generation or capture
        shift_ev = 1'b0;
        if (master) begin
            if (clk_ok && mclk_edge) begin
                if (10'(q.ecnt + 10'h1) >= ediv) begin
                    n.ecnt = '0;
                    n.sclk = ~q.sclk;
                    if (~q.sclk == pol) begin
                        shift_ev = 1'b1;
                        if (10'(q.mbit + 10'h1) >= half_bits) begin
                            n.mbit = '0;
                            n.lr   = ~q.lr;
                        end else begin
                            n.mbit = 10'(q.mbit + 10'h1);
                        end
                    end
                end else begin
                    n.ecnt = 10'(q.ecnt + 10'h1);
                end
            end
            lr_now = n.lr;
        end else begin
            n.ecnt   = '0;
            n.mbit   = '0;
            n.sclk   = pol;
            shift_ev = (q.sclk_s[1] != q.sclk_s[2]) && (q.sclk_s[1] == pol);
            lr_now   = q.lr_s[1];
        end
        // Serialiser
        lr_chg = lr_now != q.lr_prev;
        left   = (fmt == aud_out_pkg::FMT_I2S) ? ~lr_now : lr_now;
        nc     = lr_chg ? 10'h0 : ((&q.bitcnt) ? q.bitcnt : 10'(q.bitcnt + 10'h1));
        load   = '0;
        if (shift_ev) begin
            n.lr_prev = lr_now;
            n.bitcnt  = nc;
            if (lr_chg) begin
                n.half_len = 10'(q.bitcnt + 10'h1);
                if (q.settle != 2'h3) begin
                    n.settle = 2'(q.settle + 2'h1);
                end
            end
            for (int i = 0; i < 3; i++) begin
                slots = (i == 0) ? slots0 : ((fmt == aud_out_pkg::FMT_MC) ? 2'h0 : 2'h1);
                case (fmt)
                    aud_out_pkg::FMT_I2S: st = 10'h1;
                    aud_out_pkg::FMT_RJ:  st = (q.half_len > 10'(word * slots))
                                             ? 10'(q.half_len - 10'(word * slots)) : 10'h0;
                    default:              st = 10'h0;
                endcase
                st = 10'(st + {9'h0, q.ctrl[aud_out_pkg::CTRL_DELAY]});
                sl = q.slot[i];
                if (slots == 2'h0) begin
                    n.act[i] = 1'b0;
                end else if (nc == st) begin
                    load[i] = 1'b1;
                    sl      = 2'h0;
                end else if (q.act[i] && q.sbit[i] == 5'(word - 5'h1)) begin
                    if (2'(q.slot[i] + 2'h1) < slots && q.slot[i] != 2'h3) begin
                        load[i] = 1'b1;
                        sl      = 2'(q.slot[i] + 2'h1);
                    end else begin
                        n.act[i] = 1'b0;
                    end
                end else if (q.act[i]) begin
                    n.sbit[i] = 5'(q.sbit[i] + 5'h1);
                    n.sh[i]   = q.sh[i] << 1;
                end
                if (load[i]) begin
                    lch       = (i == 0) ? {sl, ~left} : {2'(i), ~left};
                    src       = q.map[3 * lch +: 3];
                    smp       = (src < 3'h6) ? q.ch[src] : 20'h0;
                    n.slot[i] = sl;
                    n.act[i]  = 1'b1;
                    n.sbit[i] = '0;
                    n.sh[i]   = align(smp, word);
                end
                n.dout[i] = n.act[i] && n.sh[i][19];
            end
        end
        n.dout = n.dout & den;
        // Transmitter timing source
        tx_ok = q.ctrl[aud_out_pkg::CTRL_TX_EN] && (!q.ctrl[aud_out_pkg::CTRL_TX_MCLK]
                || msel == aud_out_pkg::M256 || msel == aud_out_pkg::M512);
        tinc  = !q.ctrl[aud_out_pkg::CTRL_TX_MCLK] || mclk_edge;
        tterm = !q.ctrl[aud_out_pkg::CTRL_TX_MCLK] ? 8'(TX_HALF_CYC - 1)
              : (msel == aud_out_pkg::M512 ? 8'(aud_out_pkg::TX_EDGES_512 - 8'h1)
                                           : 8'(aud_out_pkg::TX_EDGES_256 - 8'h1));
        tx_tick = tx_ok && tinc && q.tdiv >= tterm;
        nh      = 6'(q.hc + 6'h1);
        // Register reads, after the status terms are settled; data stands one cycle
        if (i_rd) begin
            case (i_addr)
                aud_out_pkg::REG_CTRL:   n.rdata = q.ctrl;
                aud_out_pkg::REG_STATUS: n.rdata = {20'h0, q.frame, tx_ok, clk_ok, lr_now, q.lr};
                aud_out_pkg::REG_MAP:    n.rdata = {14'h0, q.map};
                aud_out_pkg::REG_CSTAT:  n.rdata = q.cstat;
                default: begin
                    if (ch_hit(i_addr)) begin
                        n.rdata = {12'h0, q.ch[ch_idx(i_addr)]};
                    end
                end
            endcase
        end
        if (!tx_ok) begin
            n.tdiv  = '0;
            n.hc    = aud_out_pkg::HC_LAST;
            n.sub   = 1'b1;
            n.frame = aud_out_pkg::BLOCK_LAST;
            n.tline = 1'b0;
        end else if (tinc) begin
            n.tdiv = (q.tdiv >= tterm) ? 8'h0 : 8'(q.tdiv + 8'h1);
        end
        // Biphase encoder, one step per half cell
        if (tx_tick) begin
            n.hc = nh;
            if (q.hc == aud_out_pkg::HC_LAST) begin
                nsub = ~q.sub;
                nfr  = q.frame;
                if (!nsub) begin
                    nfr = (q.frame == aud_out_pkg::BLOCK_LAST) ? 8'h0 : 8'(q.frame + 8'h1);
                end
                w[27:8] = nsub ? q.ch[1] : q.ch[0];
                w[28]   = q.ctrl[aud_out_pkg::CTRL_TX_CMP];
                w[30]   = (nfr < aud_out_pkg::CSTAT_BITS) ? q.cstat[nfr[4:0]] : 1'b0;
                w[31]   = ^w[30:4];
                n.sub   = nsub;
                n.frame = nfr;
                n.tword = w;
                n.tpre  = nsub ? aud_out_pkg::PRE_SUB_B
                        : (nfr == 8'h0 ? aud_out_pkg::PRE_BLOCK : aud_out_pkg::PRE_SUB_A);
                n.tpol  = q.tline;
                n.tline = n.tpre[7] ^ q.tline;
            end else if (nh < 6'h8) begin
                n.tline = q.tpre[3'(3'h7 - nh[2:0])] ^ q.tpol;
            end else if (!nh[0]) begin
                n.tline = ~q.tline;
            end else if (q.tword[nh[5:1]]) begin
                n.tline = ~q.tline;
            end
        end
    end

    // State register; clock pins start as inputs
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            q           <= '0;
            q.ctrl      <= aud_out_pkg::CTRL_RESET;
            q.mclk_oe_n <= 1'b1;
            q.sclk_oe_n <= 1'b1;
            q.lr_oe_n   <= 1'b1;
            q.hc        <= aud_out_pkg::HC_LAST;
            q.sub       <= 1'b1;
            q.frame     <= aud_out_pkg::BLOCK_LAST;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state register
    assign o_rdata             = q.rdata;
    assign o_mclk              = q.mclk_int;
    assign o_mclk_oe_n         = q.mclk_oe_n;
    assign o_sclk              = q.sclk;
    assign o_sclk_oe_n         = q.sclk_oe_n;
    assign o_lrclk             = q.lr;
    assign o_lrclk_oe_n        = q.lr_oe_n;
    assign o_audio_data_line_0 = q.dout[0];
    assign o_audio_data_line_1 = q.dout[1];
    assign o_audio_data_line_2 = q.dout[2];
    assign o_biphase_tx_out    = q.tline;

    // Checks
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);

    AST_MCLK_DIR: assert property (1 |=> o_mclk_oe_n == !$past(q.ctrl[aud_out_pkg::CTRL_MCLK_OUT]))
        else $error("master clock direction does not follow control");
    AST_CLK_DIR: assert property (1 |=> o_sclk_oe_n == o_lrclk_oe_n && o_sclk_oe_n == !$past(master))
        else $error("bit and frame clock directions differ");
    AST_SLAVE_SHIFT: assert property (!master && !shift_ev && $stable(den)
        |=> $stable(o_audio_data_line_0))
        else $error("slave data moved without a bit clock edge");
    AST_BAD_RATIO: assert property (master && !clk_ok ##1 master && !clk_ok |-> $stable(o_sclk))
        else $error("bit clock runs with an illegal ratio");
    AST_NO_384_OUT: assert property (master && msel == aud_out_pkg::M384
        && q.ctrl[aud_out_pkg::CTRL_MCLK_OUT] |=> $stable(o_lrclk))
        else $error("frame clock runs from a driven 384 Fs master clock");
    AST_HALF_LEN: assert property (master && $stable(q.ctrl) && q.settle == 2'h3 && shift_ev && lr_chg
        |-> 10'(q.bitcnt + 10'h1) == half_bits)
        else $error("frame half length wrong");
    AST_DATA_OFF: assert property (!den[0] |=> !o_audio_data_line_0)
        else $error("disabled data line driven high");
    AST_LR_EDGE: assert property (master && $changed(o_lrclk) |-> $changed(o_sclk) && o_sclk == pol)
        else $error("frame clock moved off the inactive bit clock edge");
    AST_I2S_START: assert property (load[0] && fmt == aud_out_pkg::FMT_I2S && !q.ctrl[aud_out_pkg::CTRL_DELAY]
        && slots0 == 2'h1 |-> nc == 10'h1)
        else $error("I2S word not one bit late");
    AST_CELL_EDGE: assert property (tx_tick && nh >= 6'h8 && !nh[0] |=> $changed(o_biphase_tx_out))
        else $error("biphase cell boundary without transition");
    AST_PARITY: assert property (tx_tick && q.hc == aud_out_pkg::HC_LAST |=> ^q.tword[31:4] == 1'b0)
        else $error("subframe parity odd");

    COV_MASTER_FRAME: cover property (master && clk_ok && shift_ev && lr_chg);
    COV_MC_SLOT2: cover property (fmt == aud_out_pkg::FMT_MC && load[0] && n.slot[0] == 2'h2);
    COV_BLOCK_START: cover property (tx_tick && q.hc == aud_out_pkg::HC_LAST && q.frame == 8'hbf);
    COV_SLAVE_SHIFT: cover property (!master && shift_ev && lr_chg);

endmodule // aud_out_port

// file: tb/aud_sink_model.sv
/*
 * Far-side model: serial receiver on data line zero, and clock source in slave mode.
 * Assumes the bench resolves the bit and frame clock pins from both enables.
 */
module aud_sink_model (
    input  wire logic        clk,
    input  wire logic        i_slave,
    input  wire logic        i_i2s,
    input  wire logic        i_sclk,
    input  wire logic        i_lrclk,
    input  wire logic        i_data,
    output logic             o_sclk,
    output logic             o_lrclk,
    output logic      [19:0] o_word,
    output int               o_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    int          div = 0;
    int          nb = 0;
    int          bit_i = 99;
    logic [19:0] sh = 20'h0;
    logic        lr_last = 1'b0;

    initial begin
        o_sclk = 1'b0;
        o_lrclk = 1'b0;
        o_word = 20'h0;
        o_cnt = 0;
    end

    // Slave clocks, still unless slave: bit clock 16 cycles, 32 bits a half
    always @(posedge clk) begin
        if (i_slave) begin
            div = (div + 1) % 8;
            if (div == 0) begin
                o_sclk <= ~o_sclk;
                nb = o_sclk ? (nb + 1) % 32 : nb;
                if (o_sclk && nb == 0) begin
                    o_lrclk <= ~o_lrclk;
                end
            end
        end
    end

    // Capture 20 bits of the left half, MSB first, on rising bit clock
    always @(posedge i_sclk) begin
        if (i_lrclk !== lr_last) begin
            bit_i = i_i2s ? -1 : 0;
        end
        lr_last = i_lrclk;
        if ((i_i2s ? !i_lrclk : i_lrclk) && bit_i >= 0 && bit_i < 20) begin
            sh = {sh[18:0], i_data};
            if (bit_i == 19) begin
                o_word = sh;
                o_cnt++;
            end
        end
        bit_i++;
    end
endmodule // aud_sink_model

// file: tb/tb_top.sv
/*
 * Self-checking bench of the audio output port: reset, registers, master LJ,
 * slave I2S and transmitter activity. Assumes the sink model beside it.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        I_CLOCK = 0;
    logic        I_RST_B = 0;
    logic        i_wr = 0;
    logic        i_rd = 0;
    logic        i_mclk = 0;
    logic        slave = 0;
    logic        i2s = 0;
    logic        txp = 0;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] lfsr = 32'h5489;
    logic [31:0] v;
    logic [31:0] o_rdata;
    logic        o_mclk, mo, so, lo, o_sclk, o_lrclk, l0, l1, l2, tx, m_sclk, m_lr;
    logic [19:0] word;
    int          cnt, txe, run, rmax;
    int          nm = 0, ns = 0, nm_f = 0, ns_f = 0;
    logic        mp = 0, sp = 0, lp = 0;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          q[$];
    wire         sclk_w = so ? m_sclk : o_sclk;
    wire         lr_w = lo ? m_lr : o_lrclk;

    always #5 I_CLOCK = ~I_CLOCK;

    aud_out_port #(.MCLK_HALF_CYC(2), .TX_HALF_CYC(4)) DUT (
        .I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mclk(i_mclk), .o_mclk(o_mclk),
        .o_mclk_oe_n(mo), .i_sclk(sclk_w), .o_sclk(o_sclk), .o_sclk_oe_n(so),
        .i_lrclk(lr_w), .o_lrclk(o_lrclk), .o_lrclk_oe_n(lo), .o_audio_data_line_0(l0),
        .o_audio_data_line_1(l1), .o_audio_data_line_2(l2), .o_biphase_tx_out(tx));

    aud_sink_model sink (.clk(I_CLOCK), .i_slave(slave), .i_i2s(i2s), .i_sclk(sclk_w),
        .i_lrclk(lr_w), .i_data(l0), .o_sclk(m_sclk), .o_lrclk(m_lr), .o_word(word),
        .o_cnt(cnt));

    // Next value of the random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Master clock toggles and bit clock rises per frame clock period
    always @(posedge I_CLOCK) begin
        mp <= o_mclk;
        sp <= o_sclk;
        lp <= o_lrclk;
        if (o_lrclk && !lp) begin
            nm_f <= nm;
            ns_f <= ns;
            nm <= int'(o_mclk != mp);
            ns <= int'(o_sclk && !sp);
        end else begin
            nm <= nm + int'(o_mclk != mp);
            ns <= ns + int'(o_sclk && !sp);
        end
    end

    // Random master clock input and sample source; timeout
    always @(posedge I_CLOCK) begin
        lfsr <= lfsr_next(lfsr);
        i_mclk <= lfsr[0];
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            test_done;
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLOCK);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge I_CLOCK);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge I_CLOCK);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge I_CLOCK);
        i_rd <= 1'b0;
        #1 chk("rdata", e, o_rdata);
    endtask

    // New sample in CH0, then compare the second word received
    task automatic word_check(input string n);
        int c0;
        v = lfsr;
        q.push_back(int'(v & 32'h000f_ffff));
        wr(8'h10, v);
        c0 = cnt;
        repeat (20000) if (cnt < c0 + 2) @(posedge I_CLOCK);
        chk(n, q[$], {12'h0, word});
    endtask

    // Edge counts over one full frame clock period
    task automatic rate_check(input int em, input int es);
        @(posedge o_lrclk);
        @(posedge I_CLOCK);
        #1 chk("mclk_frame", em, nm_f);
        chk("sclk_frame", es, ns_f);
    endtask

    task automatic test_done;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge I_CLOCK);
        chk("oe_n_rst", 32'h7, {29'h0, mo, so, lo});
        I_RST_B <= 1'b1;
        @(posedge I_CLOCK);
        #1 chk("lines", 32'h0, {29'h0, l0, l1, l2});
        chk("oe_n", 32'h7, {29'h0, mo, so, lo});
        rd(8'h00, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0);
        wr(8'h08, 32'h0002_c688);
        wr(8'h00, 32'h001c_5027);
        @(posedge I_CLOCK);
        #1 chk("oe_n_m", 32'h0, {29'h0, mo, so, lo});
        word_check("lj_word");
        rate_check(512, 64);
        wr(8'h00, 32'h001c_01b7);
        word_check("mc_word");
        rate_check(512, 128);
        i2s <= 1'b1;
        slave <= 1'b1;
        wr(8'h00, 32'h001c_5080);
        word_check("i2s_word");
        chk("oe_n_s", 32'h7, {29'h0, mo, so, lo});
        wr(8'h00, 32'h0020_0000);
        txe = 0;
        run = 0;
        rmax = 0;
        repeat (2000) begin
            @(posedge I_CLOCK);
            run = (tx !== txp) ? 0 : run + 1;
            rmax = (txe > 0 && run > rmax) ? run : rmax;
            txe += (tx !== txp);
            txp = tx;
        end
        chk("tx_edges", 32'h1, {31'h0, txe >= 200});
        chk("tx_run", 32'h1, {31'h0, rmax <= 11});
        test_done;
    end
endmodule // tb_top
